// >>> verilog/dsf_pkg.sv
// package: register map, codes and carriers for the pll override block
package dsf_pkg;

    localparam logic [3:0] OFS_STATE_FORCE  = 4'h0;
    localparam logic [3:0] OFS_SOURCE_FORCE = 4'h4;
    localparam logic [3:0] OFS_STATUS       = 4'h8;

    localparam logic [7:0] RST_STATE_FORCE  = 8'h00;
    localparam logic [7:0] RST_SOURCE_FORCE = 8'h00;

    localparam int STATE_FIELD_LSB  = 0;
    localparam int STATE_FIELD_W    = 3;
    localparam int SOURCE_FIELD_LSB = 0;
    localparam int SOURCE_FIELD_W   = 4;

    localparam logic [3:0] PRIO_HIGHEST = 4'h1;

    localparam logic [2:0] CODE_AUTO     = 3'h0;
    localparam logic [2:0] CODE_FREE_RUN = 3'h1;
    localparam logic [2:0] CODE_HOLDOVER = 3'h2;
    localparam logic [2:0] CODE_UNUSED   = 3'h3;
    localparam logic [2:0] CODE_LOCKED   = 3'h4;
    localparam logic [2:0] CODE_PRELOCK2 = 3'h5;
    localparam logic [2:0] CODE_PRELOCK  = 3'h6;
    localparam logic [2:0] CODE_PH_LOST  = 3'h7;

    typedef enum logic [2:0] {
        DSF_FREE_RUN,
        DSF_HOLDOVER,
        DSF_LOCKED,
        DSF_PRELOCK2,
        DSF_PRELOCK,
        DSF_PH_LOST
    } dsf_pll_state_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } dsf_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } dsf_wb_rsp_t;

endpackage

// >>> verilog/dsf_regs.sv
// wishbone slave holding the two override registers
`timescale 1ns/1ps
`default_nettype none
module dsf_regs (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire dsf_pkg::dsf_wb_req_t wb_req_i,
    output dsf_pkg::dsf_wb_rsp_t      wb_rsp_o,
    input  wire logic [7:0]           status_i,
    output logic [2:0]                pll_forced_state_code_o,
    output logic [3:0]                forced_input_choice_o
);
    typedef struct packed {
        logic        ack;
        logic [31:0] rdat;
        logic [7:0]  state_force;
        logic [7:0]  source_force;
    } dsf_regs_state_t;

    dsf_regs_state_t s_q;
    dsf_regs_state_t s_d;
    logic            req;

    assign req = wb_req_i.cyc && wb_req_i.stb && !s_q.ack;

    always_comb begin
        s_d = s_q;
        s_d.ack = req;
        if (req) begin
            s_d.rdat = 32'h0000_0000;
            case (wb_req_i.adr)
                dsf_pkg::OFS_STATE_FORCE:  s_d.rdat[7:0] = s_q.state_force;
                dsf_pkg::OFS_SOURCE_FORCE: s_d.rdat[7:0] = s_q.source_force;
                dsf_pkg::OFS_STATUS:       s_d.rdat[7:0] = status_i;
                default:                   s_d.rdat = 32'h0000_0000;
            endcase
            if (wb_req_i.we && wb_req_i.sel[0]) begin
                case (wb_req_i.adr)
                    // upper bits are unused and read as zero
                    dsf_pkg::OFS_STATE_FORCE:
                        s_d.state_force = {5'h00, wb_req_i.dat[2:0]};
                    dsf_pkg::OFS_SOURCE_FORCE:
                        s_d.source_force = {4'h0, wb_req_i.dat[3:0]};
                    default: s_d.state_force = s_q.state_force;
                endcase
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q.ack          <= 1'b0;
            s_q.rdat         <= 32'h0000_0000;
            s_q.state_force  <= dsf_pkg::RST_STATE_FORCE;
            s_q.source_force <= dsf_pkg::RST_SOURCE_FORCE;
        end else begin
            s_q <= s_d;
        end
    end

    assign wb_rsp_o.ack = s_q.ack;
    assign wb_rsp_o.dat = s_q.rdat;
    assign pll_forced_state_code_o = s_q.state_force[2:0];
    assign forced_input_choice_o   = s_q.source_force[3:0];
endmodule
`default_nettype wire

// >>> verilog/dsf_select.sv
// priority-based input selection with forced-source override
`timescale 1ns/1ps
`default_nettype none
module dsf_select #(
    parameter int N_IN = 4
) (
    input  wire logic [3:0]        forced_input_choice_i,
    input  wire logic [N_IN*4-1:0] prio_i,
    input  wire logic [N_IN-1:0]   valid_i,
    output logic [3:0]             sel_o,
    output logic                   sel_valid_o,
    output logic                   forced_o
);
    logic [N_IN*4-1:0] eff_prio;
    logic [N_IN-1:0]   eff_valid;
    logic [3:0]        best;

    always_comb begin
        eff_prio  = prio_i;
        eff_valid = valid_i;
        forced_o  = 1'b0;
        for (int i = 0; i < N_IN; i++) begin
            if (forced_input_choice_i == 4'(i + 1)) begin
                eff_prio[i*4 +: 4] = dsf_pkg::PRIO_HIGHEST;
                eff_valid[i] = 1'b1;
                forced_o = 1'b1;
            end
        end
    end

    // lowest nonzero priority number wins; 0 means input not eligible
    always_comb begin
        best        = 4'hF;
        sel_o       = 4'h0;
        sel_valid_o = 1'b0;
        for (int i = 0; i < N_IN; i++) begin
            // first eligible input is taken outright so priority 15 still counts
            if (eff_valid[i] && eff_prio[i*4 +: 4] != 4'h0 &&
                (!sel_valid_o || eff_prio[i*4 +: 4] < best)) begin
                best        = eff_prio[i*4 +: 4];
                sel_o       = 4'(i + 1);
                sel_valid_o = 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// >>> verilog/dsf_top.sv
// pll state and source override: registers, selection and state control
`timescale 1ns/1ps
`default_nettype none
module dsf_top #(
    parameter int N_IN = 4
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire dsf_pkg::dsf_wb_req_t wb_req_i,
    output dsf_pkg::dsf_wb_rsp_t      wb_rsp_o,
    input  wire logic [N_IN*4-1:0]    input_prio_i,
    input  wire logic [N_IN-1:0]      input_valid_i,
    input  wire logic                 phase_locked_i,
    input  wire logic                 phase_lost_i,
    output logic [2:0]                pll_state_o,
    output logic [3:0]                selected_input_o,
    output logic                      selected_valid_o
);
    typedef struct packed {
        dsf_pkg::dsf_pll_state_t st;
        logic [3:0]              sel;
        logic                    sel_ok;
    } dsf_top_state_t;

    dsf_top_state_t s_q;
    dsf_top_state_t s_d;
    logic [2:0]     code;
    logic [3:0]     choice;
    logic [3:0]     sel_c;
    logic           sel_ok_c;
    logic           forced_c;
    logic [7:0]     status;

    dsf_regs u_regs (
        .clk_i                   (clk_i),
        .rst_i                   (rst_i),
        .wb_req_i                (wb_req_i),
        .wb_rsp_o                (wb_rsp_o),
        .status_i                (status),
        .pll_forced_state_code_o (code),
        .forced_input_choice_o   (choice)
    );

    dsf_select #(.N_IN(N_IN)) u_sel (
        .forced_input_choice_i (choice),
        .prio_i                (input_prio_i),
        .valid_i               (input_valid_i),
        .sel_o                 (sel_c),
        .sel_valid_o           (sel_ok_c),
        .forced_o              (forced_c)
    );

    // status byte: {selected_valid, state[2:0] as code, sel}; see note
    function automatic logic [2:0] state_code(input dsf_pkg::dsf_pll_state_t st);
        case (st)
            dsf_pkg::DSF_FREE_RUN: state_code = dsf_pkg::CODE_FREE_RUN;
            dsf_pkg::DSF_HOLDOVER: state_code = dsf_pkg::CODE_HOLDOVER;
            dsf_pkg::DSF_LOCKED:   state_code = dsf_pkg::CODE_LOCKED;
            dsf_pkg::DSF_PRELOCK2: state_code = dsf_pkg::CODE_PRELOCK2;
            dsf_pkg::DSF_PRELOCK:  state_code = dsf_pkg::CODE_PRELOCK;
            dsf_pkg::DSF_PH_LOST:  state_code = dsf_pkg::CODE_PH_LOST;
            default:               state_code = dsf_pkg::CODE_FREE_RUN;
        endcase
    endfunction

    assign status = {s_q.sel_ok, state_code(s_q.st), s_q.sel};

    always_comb begin
        s_d        = s_q;
        s_d.sel    = sel_c;
        s_d.sel_ok = sel_ok_c;
        case (code)
            dsf_pkg::CODE_AUTO: begin
                case (s_q.st)
                    dsf_pkg::DSF_FREE_RUN:
                        if (sel_ok_c) s_d.st = dsf_pkg::DSF_PRELOCK;
                    dsf_pkg::DSF_PRELOCK:
                        if (!sel_ok_c && !forced_c) s_d.st = dsf_pkg::DSF_HOLDOVER;
                        else if (phase_locked_i) s_d.st = dsf_pkg::DSF_LOCKED;
                    dsf_pkg::DSF_PRELOCK2:
                        if (!sel_ok_c && !forced_c) s_d.st = dsf_pkg::DSF_HOLDOVER;
                        else if (phase_locked_i) s_d.st = dsf_pkg::DSF_LOCKED;
                    dsf_pkg::DSF_LOCKED:
                        if (!sel_ok_c && !forced_c) s_d.st = dsf_pkg::DSF_HOLDOVER;
                        else if (phase_lost_i) s_d.st = dsf_pkg::DSF_PH_LOST;
                        else if (s_q.sel != sel_c) s_d.st = dsf_pkg::DSF_PRELOCK2;
                    dsf_pkg::DSF_PH_LOST:
                        if (!sel_ok_c && !forced_c) s_d.st = dsf_pkg::DSF_HOLDOVER;
                        else if (!phase_lost_i) s_d.st = dsf_pkg::DSF_PRELOCK2;
                    dsf_pkg::DSF_HOLDOVER:
                        if (sel_ok_c) s_d.st = dsf_pkg::DSF_PRELOCK2;
                    default: s_d.st = dsf_pkg::DSF_FREE_RUN;
                endcase
            end
            // forced codes: monitoring inputs are not looked at
            dsf_pkg::CODE_FREE_RUN: s_d.st = dsf_pkg::DSF_FREE_RUN;
            dsf_pkg::CODE_HOLDOVER: s_d.st = dsf_pkg::DSF_HOLDOVER;
            dsf_pkg::CODE_LOCKED:   s_d.st = dsf_pkg::DSF_LOCKED;
            dsf_pkg::CODE_PRELOCK2: s_d.st = dsf_pkg::DSF_PRELOCK2;
            dsf_pkg::CODE_PRELOCK:  s_d.st = dsf_pkg::DSF_PRELOCK;
            dsf_pkg::CODE_PH_LOST:  s_d.st = dsf_pkg::DSF_PH_LOST;
            // unused code: hold the current state rather than invent one
            default:                s_d.st = s_q.st;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q.st     <= dsf_pkg::DSF_FREE_RUN;
            s_q.sel    <= 4'h0;
            s_q.sel_ok <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign pll_state_o      = state_code(s_q.st);
    assign selected_input_o = s_q.sel;
    assign selected_valid_o = s_q.sel_ok;
endmodule
`default_nettype wire

// >>> verif/dsf_assertions.sv
// checker: port-level assertions for the pll override block
`timescale 1ns/1ps
`default_nettype none
module dsf_chk #(
    parameter int N_IN = 4
) (
    input wire logic                 clk_i,
    input wire logic                 rst_i,
    input wire dsf_pkg::dsf_wb_req_t wb_req_i,
    input wire dsf_pkg::dsf_wb_rsp_t wb_rsp_o,
    input wire logic [N_IN-1:0]      input_valid_i,
    input wire logic [2:0]           pll_state_o,
    input wire logic [3:0]           selected_input_o,
    input wire logic                 selected_valid_o
);
    logic [2:0] fs_q;
    logic [3:0] src_q;
    logic       wr;
    logic       fsv;
    // shadow copies follow the bus, stored at the taking edge like the slave
    assign wr  = wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack
                 && wb_req_i.we && wb_req_i.sel[0];
    assign fsv = src_q != 4'h0 && src_q <= N_IN;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fs_q  <= 3'h0;
            src_q <= 4'h0;
        end else if (wr && wb_req_i.adr == dsf_pkg::OFS_STATE_FORCE) begin
            fs_q <= wb_req_i.dat[2:0];
        end else if (wr && wb_req_i.adr == dsf_pkg::OFS_SOURCE_FORCE) begin
            src_q <= wb_req_i.dat[3:0];
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_ACK_NEXT: assert property (
        wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack |=> wb_rsp_o.ack)
        else $error("ack not given one cycle after request");
    AST_ACK_PULSE: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
        else $error("ack held longer than one cycle");
    AST_OUT_RESET: assert property (
        $fell(rst_i) |-> pll_state_o == 3'h1 && selected_input_o == 4'h0 && !selected_valid_o)
        else $error("outputs not at reset values");
    AST_FORCED_STATE: assert property (
        fs_q != 3'h0 && fs_q != 3'h3 |=> pll_state_o == $past(fs_q))
        else $error("forced state not applied");
    AST_FORCED_VALID: assert property (fsv |=> selected_valid_o)
        else $error("forced input not taken as valid");
    AST_NO_HOLD: assert property (
        (fsv && fs_q == 3'h0) [*4] |-> pll_state_o != 3'h2)
        else $error("holdover while a source is forced");
    AST_NONE_VALID: assert property (
        src_q == 4'h0 && input_valid_i == '0 |=> !selected_valid_o)
        else $error("selection with no valid input");
    AST_AUTO_PRELOCK: assert property (
        fs_q == 3'h0 && pll_state_o == 3'h1 && selected_valid_o |=> pll_state_o == 3'h6)
        else $error("free run did not start acquisition");
    AST_RD_STATE: assert property (
        wb_rsp_o.ack && !wb_req_i.we && wb_req_i.adr == dsf_pkg::OFS_STATE_FORCE
        |-> wb_rsp_o.dat == {29'h0, fs_q})
        else $error("state force readback wrong");
    AST_RD_SRC: assert property (
        wb_rsp_o.ack && !wb_req_i.we && wb_req_i.adr == dsf_pkg::OFS_SOURCE_FORCE
        |-> wb_rsp_o.dat == {28'h0, src_q})
        else $error("source force readback wrong");
    cover property (fsv ##1 selected_valid_o);
    cover property (fs_q == 3'h7 ##1 pll_state_o == 3'h7);
    cover property (wb_rsp_o.ack && wb_req_i.we);
endmodule
bind dsf_top dsf_chk #(.N_IN(N_IN)) u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
    .wb_rsp_o(wb_rsp_o), .input_valid_i(input_valid_i), .pll_state_o(pll_state_o),
    .selected_input_o(selected_input_o), .selected_valid_o(selected_valid_o));
`default_nettype wire

// >>> verif/tb.sv
// self-checking bench for the pll override block
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic                 clk_i;
    logic                 rst_i;
    dsf_pkg::dsf_wb_req_t rq;
    dsf_pkg::dsf_wb_rsp_t rs;
    logic [15:0]          prio;
    logic [3:0]           vld;
    logic                 lock;
    logic                 lost;
    logic [2:0]           st;
    logic [3:0]           sel;
    logic                 selv;
    logic [31:0]          rd;
    int                   fails;
    int                   n_checks;
    int                   cyc_n;
    dsf_top #(.N_IN(4)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(rq), .wb_rsp_o(rs),
        .input_prio_i(prio), .input_valid_i(vld), .phase_locked_i(lock), .phase_lost_i(lost),
        .pll_state_o(st), .selected_input_o(sel), .selected_valid_o(selv));
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n > 2000) begin
            fails++;
            close_out();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one classic cycle; ack and data are the values sampled at the edge
    task automatic wb(input logic we, input logic [3:0] a, input logic [3:0] s,
                      input logic [31:0] d);
        int n = 0;
        rq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: s, dat: d};
        do begin
            @(posedge clk_i);
            n++;
        end while (rs.ack !== 1'b1 && n < 20);
        rd = rs.dat;
        rq <= '0;
        if (n >= 20) fails++;
        @(posedge clk_i);
    endtask
    task automatic wait_state(input logic [2:0] s);
        int n = 0;
        while (st !== s && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        chk("state reached", 32'(s), 32'(st));
    endtask
    task automatic do_reset();
        rst_i <= 1'b1;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic t_reset();
        chk("reset state", 32'h1, 32'(st));
        chk("reset sel", 32'h0, {27'h0, selv, sel});
        wb(1'b0, dsf_pkg::OFS_STATE_FORCE, 4'hF, 32'h0);
        chk("reset state force", 32'h0, rd);
        wb(1'b0, dsf_pkg::OFS_SOURCE_FORCE, 4'hF, 32'h0);
        chk("reset source force", 32'h0, rd);
    endtask
    task automatic t_state();
        logic [2:0] c [6];
        c = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
        // monitors shout loss meanwhile, so only the force can hold the state
        lost <= 1'b1;
        foreach (c[i]) begin
            wb(1'b1, dsf_pkg::OFS_STATE_FORCE, 4'hF, {24'h0, 5'h1F, c[i]});
            repeat (3) @(posedge clk_i);
            chk("forced state", 32'(c[i]), 32'(st));
            wb(1'b0, dsf_pkg::OFS_STATE_FORCE, 4'hF, 32'h0);
            chk("state field", 32'(c[i]), rd);
        end
        wb(1'b1, dsf_pkg::OFS_STATE_FORCE, 4'hF, 32'h3);
        repeat (3) @(posedge clk_i);
        chk("unused code", 32'h7, 32'(st));
        wb(1'b1, dsf_pkg::OFS_STATE_FORCE, 4'hF, 32'h0);
    endtask
    task automatic t_auto();
        do_reset();
        // hold free run first so the release to automatic control is seen
        wb(1'b1, dsf_pkg::OFS_STATE_FORCE, 4'hF, 32'h1);
        lost <= 1'b0;
        prio <= 16'h3002;
        vld  <= 4'h1;
        repeat (3) @(posedge clk_i);
        chk("auto sel", 32'h11, {27'h0, selv, sel});
        chk("held free run", 32'h1, 32'(st));
        wb(1'b1, dsf_pkg::OFS_STATE_FORCE, 4'hF, 32'h0);
        wait_state(3'h6);
        lock <= 1'b1;
        wait_state(3'h4);
    endtask
    task automatic t_src();
        // input 3 is invalid and ineligible, so only the force can pick it
        // no other input sits at priority one, standing in for revertive mode
        wb(1'b1, dsf_pkg::OFS_SOURCE_FORCE, 4'hF, 32'hFFFF_FFF3);
        wb(1'b0, dsf_pkg::OFS_SOURCE_FORCE, 4'hF, 32'h0);
        chk("source field", 32'h3, rd);
        chk("forced sel", 32'h13, {27'h0, selv, sel});
        wait_state(3'h4);
        wb(1'b0, dsf_pkg::OFS_STATUS, 4'hF, 32'h0);
        chk("status", 32'hC3, rd);
        vld <= 4'h0;
        repeat (4) @(posedge clk_i);
        chk("no holdover", 32'h1, 32'(st !== 3'h2));
        wb(1'b1, dsf_pkg::OFS_SOURCE_FORCE, 4'hF, 32'h0);
        repeat (2) @(posedge clk_i);
        chk("released sel", 32'h0, 32'(selv));
        wb(1'b0, 4'hC, 4'hF, 32'h0);
        chk("unmapped read", 32'h0, rd);
        wb(1'b1, dsf_pkg::OFS_STATE_FORCE, 4'hE, 32'h2);
        wb(1'b0, dsf_pkg::OFS_STATE_FORCE, 4'hF, 32'h0);
        chk("masked write", 32'h0, rd);
    endtask
    initial begin
        rst_i    = 1'b1;
        rq       = '0;
        prio     = 16'h0;
        vld      = 4'h0;
        lock     = 1'b0;
        lost     = 1'b0;
        fails    = 0;
        n_checks = 0;
        cyc_n    = 0;
        do_reset();
        t_reset();
        t_state();
        t_auto();
        t_src();
        close_out();
    end
endmodule
`default_nettype wire
